//--- hw/bmsl_defs.vh
`ifndef BMSL_DEFS_VH
`define BMSL_DEFS_VH
// ----------------------------------------
// timing and sizes
// ----------------------------------------
`define BMSL_CLK_DIV 256
`define BMSL_HALF_DIV 8'h7F
`define BMSL_DIV_W 8
`define BMSL_STREAM_BITS 256
`define BMSL_CNT_W 9
`define BMSL_LAST_BIT 9'h0FF
`define BMSL_MODE_W 21
`define BMSL_MODE_RESET 21'h00000
// ----------------------------------------
// field positions
// ----------------------------------------
`define BMSL_F_BLK_ORDER 0
`define BMSL_F_CHK_PAR 1
`define BMSL_F_BIG_END 2
`define BMSL_F_DSH_DIS 3
`define BMSL_F_SLC_ABS 4
`define BMSL_F_SYSW_LO 5
`define BMSL_F_SYSW_HI 6
`define BMSL_F_SLPW 7
`define BMSL_F_SPLIT 8
`define BMSL_F_LINE_LO 9
`define BMSL_F_LINE_HI 10
`define BMSL_F_XMIT_LO 11
`define BMSL_F_XMIT_HI 14
`define BMSL_F_DIV_LO 15
`define BMSL_F_DIV_HI 17
`define BMSL_F_RSV18 18
`define BMSL_F_TMR_DIS 19
`define BMSL_F_POT_DIS 20
// ----------------------------------------
// legal encoding limits
// ----------------------------------------
`define BMSL_SYSW_LEGAL 2'h0
`define BMSL_XMIT_MAX 4'h8
`define BMSL_DIV_MAX 3'h2
// ----------------------------------------
// register map (apb byte addresses)
// ----------------------------------------
`define BMSL_A_MODE 12'h000
`define BMSL_A_STAT 12'h004
`define BMSL_A_CTRL 12'h008
`define BMSL_ST_DONE 0
`define BMSL_ST_BUSY 1
`define BMSL_ST_RSV 2
`define BMSL_ST_ENC 3
`define BMSL_CT_RELOAD 0
`endif

//--- hw/bmsl_loader.v
`include "bmsl_defs.vh"
// ----------------------------------------
// boot mode serial loader with apb status
// ----------------------------------------
module bmsl_loader
(
  input wire pclk,
  input wire presetn,
  input wire power_good,
  input wire boot_serial_data_in,
  output reg boot_serial_clock,
  output reg load_complete,
  output reg block_read_order_sel,
  output reg check_bus_parity_sel,
  output reg big_endian_sel,
  output reg dirty_shared_disable,
  output reg second_level_cache_absent,
  output reg [1:0] system_port_width,
  output reg second_level_port_width,
  output reg second_level_split_sel,
  output reg [1:0] second_level_line_size,
  output reg [3:0] transmit_data_pattern,
  output reg [2:0] system_clock_divisor,
  output reg timer_interrupt_disable,
  output reg potential_invalidate_disable,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_SHIFT = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`BMSL_DIV_W-1:0] div_cnt;
  reg [`BMSL_CNT_W-1:0] bit_cnt;
  reg [`BMSL_MODE_W-1:0] mode;
  reg rsv_bad;
  reg reload_req;
  wire pg_s;
  wire din_s;
  wire rise_en;
  wire fall_en;
  wire apb_wr;
  wire apb_rd;
  wire shift_tick;
  wire load_done_edge;
  wire [`BMSL_MODE_W-1:0] cap_en;
  reg enc_bad;

  // pins come from outside the clock domain
  bmsl_sync u_sync_pg
  (
    .pclk(pclk),
    .presetn(presetn),
    .din(power_good),
    .dout(pg_s)
  );

  bmsl_sync u_sync_din
  (
    .pclk(pclk),
    .presetn(presetn),
    .din(boot_serial_data_in),
    .dout(din_s)
  );

  // ----------------------------------------
  // clock divider
  // ----------------------------------------
  // free-running divide by 256, half period each level
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= {`BMSL_DIV_W{1'b0}};
    else
      div_cnt <= div_cnt + 1'b1;
  end

  assign rise_en = (div_cnt == `BMSL_HALF_DIV);
  assign fall_en = (div_cnt == {`BMSL_DIV_W{1'b1}});

  // clock keeps toggling after the load completes
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boot_serial_clock <= 1'b0;
    else if (rise_en)
      boot_serial_clock <= 1'b1;
    else if (fall_en)
      boot_serial_clock <= 1'b0;
  end

  // ----------------------------------------
  // load sequencer
  // ----------------------------------------
  // sample on the falling edge so the source had a full high half to settle
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (pg_s && fall_en)
          next_state = ST_SHIFT;
      ST_SHIFT:
        if (!pg_s)
          next_state = ST_IDLE; // power loss abandons a partial stream
        else if (fall_en && bit_cnt == `BMSL_LAST_BIT)
          next_state = ST_DONE;
      ST_DONE:
        if (reload_req || !pg_s)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // shared strobes of the sequencer
  assign shift_tick = (state == ST_SHIFT) && fall_en;
  assign load_done_edge = (state == ST_SHIFT) && (next_state == ST_DONE);

  // one capture enable per kept bit, true only at its own index
  genvar gi;
  generate
    for (gi = 0; gi < `BMSL_MODE_W; gi = gi + 1)
    begin : g_cap
      assign cap_en[gi] = shift_tick && (bit_cnt == gi);
    end
  endgenerate

  // bit counter; first sample taken on the edge after entering shift
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bit_cnt <= {`BMSL_CNT_W{1'b0}};
    else if (state != ST_SHIFT)
      bit_cnt <= {`BMSL_CNT_W{1'b0}};
    else if (fall_en)
      bit_cnt <= bit_cnt + 1'b1;
  end

  // bit n lands at position n; only the low fields are kept
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= `BMSL_MODE_RESET;
      rsv_bad <= 1'b0;
    end
    else if (shift_tick) // data ignored outside shift
    begin
      mode <= (mode & ~cap_en) | ({`BMSL_MODE_W{din_s}} & cap_en);
      if (bit_cnt == `BMSL_F_RSV18)
        rsv_bad <= din_s;
    end
  end

  // load-complete holds the rest of the core in reset until valid
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      load_complete <= 1'b0;
    else
      load_complete <= (next_state == ST_DONE);
  end

  // ----------------------------------------
  // decoded mode outputs
  // ----------------------------------------
  // outputs only update at completion, so they never show a partial stream
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      block_read_order_sel <= 1'b0;
      check_bus_parity_sel <= 1'b0;
      big_endian_sel <= 1'b0;
      dirty_shared_disable <= 1'b0;
      second_level_cache_absent <= 1'b0;
      system_port_width <= 2'h0;
      second_level_port_width <= 1'b0;
      second_level_split_sel <= 1'b0;
      second_level_line_size <= 2'h0;
      transmit_data_pattern <= 4'h0;
      system_clock_divisor <= 3'h0;
      timer_interrupt_disable <= 1'b0;
      potential_invalidate_disable <= 1'b0;
    end
    else if (load_done_edge)
    begin
      block_read_order_sel <= mode[`BMSL_F_BLK_ORDER];
      check_bus_parity_sel <= mode[`BMSL_F_CHK_PAR];
      big_endian_sel <= mode[`BMSL_F_BIG_END];
      dirty_shared_disable <= mode[`BMSL_F_DSH_DIS];
      second_level_cache_absent <= mode[`BMSL_F_SLC_ABS];
      system_port_width <= mode[`BMSL_F_SYSW_HI:`BMSL_F_SYSW_LO];
      second_level_port_width <= mode[`BMSL_F_SLPW];
      second_level_split_sel <= mode[`BMSL_F_SPLIT];
      second_level_line_size <= mode[`BMSL_F_LINE_HI:`BMSL_F_LINE_LO];
      transmit_data_pattern <= mode[`BMSL_F_XMIT_HI:`BMSL_F_XMIT_LO];
      system_clock_divisor <= mode[`BMSL_F_DIV_HI:`BMSL_F_DIV_LO];
      timer_interrupt_disable <= mode[`BMSL_F_TMR_DIS];
      potential_invalidate_disable <= mode[`BMSL_F_POT_DIS];
    end
  end

  // ----------------------------------------
  // reserved encoding watch
  // ----------------------------------------
  // behaviour is undefined for these, so software gets a flag to refuse the image
  function enc_reserved;
    input [`BMSL_MODE_W-1:0] m;
    begin
      enc_reserved = (m[`BMSL_F_SYSW_HI:`BMSL_F_SYSW_LO] != `BMSL_SYSW_LEGAL) || m[`BMSL_F_SLPW] ||
        m[`BMSL_F_SPLIT] || (m[`BMSL_F_XMIT_HI:`BMSL_F_XMIT_LO] > `BMSL_XMIT_MAX) ||
        (m[`BMSL_F_DIV_HI:`BMSL_F_DIV_LO] > `BMSL_DIV_MAX);
    end
  endfunction

  // taken with the outputs, so the flag always matches the fields shown
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      enc_bad <= 1'b0;
    else if (load_done_edge)
      enc_bad <= enc_reserved(mode);
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // zero wait states; unmapped addresses answer with an error
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `BMSL_A_MODE) || (a == `BMSL_A_STAT) || (a == `BMSL_A_CTRL);
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign apb_wr = psel && penable && pwrite && is_mapped(paddr);
  assign apb_rd = psel && !penable && !pwrite;

  // writing the reload bit in done restarts the stream; self-clears once taken, dropped in other states
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reload_req <= 1'b0;
    else if (apb_wr && paddr == `BMSL_A_CTRL)
      reload_req <= pwdata[`BMSL_CT_RELOAD];
    else if (state != ST_DONE)
      reload_req <= 1'b0;
  end

  // read data registered in setup so it is stable through access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (apb_rd)
    begin
      prdata <= 32'h00000000;
      case (paddr)
        `BMSL_A_MODE:
          prdata[`BMSL_MODE_W-1:0] <= mode;
        `BMSL_A_STAT:
        begin
          prdata[`BMSL_ST_DONE] <= load_complete;
          prdata[`BMSL_ST_BUSY] <= (state == ST_SHIFT);
          prdata[`BMSL_ST_RSV] <= rsv_bad; // flags a bad reserved bit only
          prdata[`BMSL_ST_ENC] <= enc_bad;
        end
        `BMSL_A_CTRL:
          prdata[`BMSL_CT_RELOAD] <= reload_req;
        default:
          prdata <= 32'h00000000;
      endcase
    end
  end
endmodule // bmsl_loader

//--- hw/bmsl_sync.v
`include "bmsl_defs.vh"
// ----------------------------------------
// three-stage input synchroniser
// ----------------------------------------
module bmsl_sync
(
  input wire pclk,
  input wire presetn,
  input wire din,
  output reg dout
);
  reg s1;
  reg s2;
  reg s3;
  // s1 feeds only s2; value accepted when s2 and s3 agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        dout <= s3;
    end
  end
endmodule // bmsl_sync

//--- sim/bmsl_eprom.sv
// ------------------------------
// serial mode memory model
// ------------------------------
module bmsl_eprom
(
  input wire power_good,
  input wire boot_serial_clock,
  input wire [255:0] image,
  output logic boot_serial_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0;
  initial boot_serial_data_in = 1'b0;
  // next bit after each rise; toggles when idle so stale data never looks valid
  always @(posedge boot_serial_clock)
  begin
    if (!power_good || idx > 255)
    begin
      idx <= power_good ? idx : 0;
      boot_serial_data_in <= ~boot_serial_data_in;
    end
    else
    begin
      boot_serial_data_in <= image[idx];
      idx <= idx + 1;
    end
  end
endmodule // bmsl_eprom

//--- sim/bmsl_monitor.sv
// ------------------------------
// loader port checker
// ------------------------------
module bmsl_monitor
(
  input wire pclk,
  input wire presetn,
  input wire power_good,
  input wire boot_serial_clock,
  input wire load_complete,
  input wire block_read_order_sel,
  input wire check_bus_parity_sel,
  input wire big_endian_sel,
  input wire [3:0] transmit_data_pattern,
  input wire [2:0] system_clock_divisor,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev;
  logic seen;
  logic [7:0] run;
  logic [9:0] falls;
  // half-period counter; first phase after reset is skipped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prev <= 1'b0;
      seen <= 1'b0;
      run <= 8'h00;
      falls <= 10'h000;
    end
    else
    begin
      prev <= boot_serial_clock;
      seen <= seen | (boot_serial_clock != prev);
      run <= (boot_serial_clock != prev) ? 8'h00 : run + 8'h01;
      falls <= !power_good ? 10'h000 : falls + {9'h000, prev && !boot_serial_clock};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_done; $rose(load_complete); endsequence
  sequence s_rd; psel && penable && !pwrite; endsequence
  property p_half; (boot_serial_clock != prev) && seen |-> run == 8'h7F; endproperty
  a_half: assert property (p_half) else $error("boot clock half period wrong");
  property p_edge; s_done |-> !boot_serial_clock && (prev || run == 8'h00); endproperty
  a_edge: assert property (p_edge) else $error("done not on a boot clock fall");
  property p_count; s_done |-> falls >= 10'h100 && falls <= 10'h102; endproperty
  a_count: assert property (p_count) else $error("done after wrong bit count");
  property p_drop; $fell(power_good) |-> ##[1:6] !load_complete; endproperty
  a_drop: assert property (p_drop) else $error("done kept after power loss");
  property p_hold; load_complete && $past(load_complete) |->
    $stable(transmit_data_pattern) && $stable(system_clock_divisor) && $stable(big_endian_sel); endproperty
  a_hold: assert property (p_hold) else $error("modes moved after load");
  property p_change; $changed(transmit_data_pattern) || $changed(block_read_order_sel) |-> s_done; endproperty
  a_change: assert property (p_change) else $error("modes moved outside completion");
  property p_mode; s_rd and (paddr == 12'h000 && load_complete) |->
    prdata[2:0] == {big_endian_sel, check_bus_parity_sel, block_read_order_sel}; endproperty
  a_mode: assert property (p_mode) else $error("mode word differs from outputs");
  property p_err; psel && penable |-> pready && pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}); endproperty
  a_err: assert property (p_err) else $error("apb answer wrong");
endmodule // bmsl_monitor
bind bmsl_loader bmsl_monitor i_bmsl_monitor (.pclk, .presetn, .power_good, .boot_serial_clock, .load_complete,
  .block_read_order_sel, .check_bus_parity_sel, .big_endian_sel, .transmit_data_pattern, .system_clock_divisor,
  .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .prdata);

//--- sim/tb_bmsl_loader.sv
// ------------------------------
// loader testbench
// ------------------------------
module tb_bmsl_loader;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, power_good = 0, psel = 0, penable = 0, pwrite = 0, lc_q = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, lf;
  logic [255:0] image = '0;
  logic boot_serial_data_in, boot_serial_clock, load_complete, pready, pslverr, block_read_order_sel;
  logic check_bus_parity_sel, big_endian_sel, dirty_shared_disable, second_level_cache_absent;
  logic second_level_port_width, second_level_split_sel, timer_interrupt_disable, potential_invalidate_disable;
  logic [1:0] system_port_width, second_level_line_size;
  logic [3:0] transmit_data_pattern;
  logic [2:0] system_clock_divisor;
  logic [32:0] q[$];
  int bad_count = 0, checked = 0, cyc = 0;
  wire [20:0] fld = {potential_invalidate_disable, timer_interrupt_disable, 1'b0, system_clock_divisor,
    transmit_data_pattern, second_level_line_size, second_level_split_sel, second_level_port_width,
    system_port_width, second_level_cache_absent, dirty_shared_disable, big_endian_sel, check_bus_parity_sel,
    block_read_order_sel};
  bmsl_loader i_bmsl_loader (.pclk, .presetn, .power_good, .boot_serial_data_in, .boot_serial_clock,
    .load_complete, .block_read_order_sel, .check_bus_parity_sel, .big_endian_sel, .dirty_shared_disable,
    .second_level_cache_absent, .system_port_width, .second_level_port_width, .second_level_split_sel,
    .second_level_line_size, .transmit_data_pattern, .system_clock_divisor, .timer_interrupt_disable,
    .potential_invalidate_disable, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata);
  bmsl_eprom i_bmsl_eprom (.power_good, .boot_serial_clock, .image, .boot_serial_data_in);
  initial forever #10 pclk = ~pclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // oldest note against what appeared; error answers compare only the flag
  task automatic chk(input string nm, input logic [32:0] seen);
    logic [32:0] e;
    e = q.pop_front();
    checked++;
    if (e[32] ? seen[32] !== 1'b1 : seen !== e)
    begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    if (!w) q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic complete_run;
    bad_count += q.size();
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watcher: read answers and the completion edge
  always @(posedge pclk)
  begin
    lc_q <= load_complete;
    if (psel && penable && pready && !pwrite) chk("apb read", {pslverr, prdata});
    if (load_complete === 1'b1 && lc_q !== 1'b1) chk("mode fields", {12'h000, fld});
    cyc++;
    if (cyc > 80000)
    begin
      bad_count++;
      complete_run();
    end
  end
  initial
  begin
    lf = 32'h00000020;
    repeat (40) lf = lfsr(lf);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h000, 0, 33'h0);
    apb(0, 12'h004, 0, 33'h0);
    image[20:0] = {lf[1:0], 1'b0, 3'(lf[4:2] % 3), 4'(lf[8:5] % 9), lf[10:9], 4'h0, lf[15:11]};
    @(posedge boot_serial_clock);
    @(posedge pclk);
    power_good <= 1'b1;
    repeat (4) @(posedge boot_serial_clock);
    apb(0, 12'h004, 0, 33'h2);
    // power loss mid-stream drops the load; the retry starts again from bit 0
    power_good <= 1'b0;
    @(posedge boot_serial_clock);
    apb(0, 12'h004, 0, 33'h0);
    @(posedge boot_serial_clock);
    @(posedge pclk);
    power_good <= 1'b1;
    repeat (4) @(posedge boot_serial_clock);
    apb(0, 12'h004, 0, 33'h2);
    q.push_back({12'h000, image[20:0]});
    wait (load_complete === 1'b1);
    apb(0, 12'h000, 0, {12'h000, image[20:0]});
    apb(0, 12'h004, 0, 33'h1);
    apb(1, 12'h008, 32'h00000000, 33'h0);
    apb(0, 12'h008, 0, 33'h0);
    apb(1, 12'h000, 32'hFFFFFFFF, 33'h0);
    apb(0, 12'h010, 0, {1'b1, 32'h0});
    apb(1, 12'h00C, 32'hFFFFFFFF, 33'h0);
    repeat (3) @(posedge boot_serial_clock);
    apb(0, 12'h000, 0, {12'h000, image[20:0]});
    power_good <= 1'b0;
    repeat (10) @(posedge pclk);
    complete_run();
  end
endmodule // tb_bmsl_loader
